// ---- rtl/tbc_pkg.sv ----
// constants, register map and field layout of the timebase counter
// assumes a single 100 MHz clock and a byte-wide register port
package tbc_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int         ADDR_W          = 2;
    localparam logic [1:0] OFF_COUNT       = 2'h0;
    localparam logic [1:0] OFF_CTRL        = 2'h1;
    localparam logic [1:0] OFF_IRQ_STATUS  = 2'h2;
    localparam logic [1:0] OFF_IRQ_MASK    = 2'h3;

    // ----------------------------------------------------------------
    // control/status fields
    // ----------------------------------------------------------------
    localparam int         BIT_RESERVED    = 7;
    localparam int         BIT_CASCADE     = 6;
    localparam int         BIT_OVF         = 5;
    localparam int         BIT_OVF_IE      = 4;
    localparam int         BIT_RUN         = 3;
    localparam int         SEL_MSB         = 2;
    localparam int         SEL_W           = 3;
    localparam logic [7:0] CTRL_WR_MASK    = 8'h5F;

    // ----------------------------------------------------------------
    // interrupt status layout
    // ----------------------------------------------------------------
    localparam int         IRQ_W           = 2;
    localparam int         IRQ_OVERFLOW    = 0;
    localparam int         IRQ_CASCADE     = 1;

    // ----------------------------------------------------------------
    // reset values and counts
    // ----------------------------------------------------------------
    localparam logic [7:0] COUNT_RESET     = 8'h00;
    localparam logic [7:0] CTRL_RESET      = 8'h00;
    localparam logic [7:0] COUNT_MAX       = 8'hFF;
    localparam logic [7:0] PRESCALE_RESET  = 8'h00;
    localparam logic [1:0] IRQ_RESET       = 2'h0;

    // division factor is two to the power of select plus one
    function automatic logic [7:0] tbc_div_mask(input logic [2:0] sel);
        tbc_div_mask = 8'((9'h002 << sel) - 9'h001);
    endfunction

endpackage

// ---- rtl/tbc_prescaler.sv ----
// power-of-two prescaler for the timebase counter
// assumes run and hold come from logic on the same clock
`timescale 1ns/10ps
`default_nettype none
module tbc_prescaler
    import tbc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       clk_en,
    input  wire logic       run,
    input  wire logic       hold,
    input  wire logic [2:0] sel,
    output logic            tick
);

    logic [7:0] div_reg;
    logic [7:0] mask;

    assign mask = tbc_div_mask(sel);

    // ----------------------------------------------------------------
    // divider
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= PRESCALE_RESET;
        end else if (clk_en) begin
            if (!run) begin
                div_reg <= PRESCALE_RESET;
            end else if (!hold) begin
                div_reg <= div_reg + 8'h01;
            end
        end
    end

    // low bits all ones marks the last cycle of each period
    assign tick = run && !hold && ((div_reg & mask) == mask);

endmodule // tbc_prescaler
`default_nettype wire

// ---- rtl/tbc_top.sv ----
// timebase counter with prescaler, overflow flag and interrupt logic
// assumes the register port, halt and wait inputs share clk
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module tbc_top
    import tbc_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              clk_en,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [7:0]        wr_data,
    input  wire logic              wr_en,
    input  wire logic              rd_en,
    output logic      [7:0]        rd_data,
    input  wire logic              halt_mode,
    input  wire logic              wait_mode,
    output logic                   irq,
    output logic                   wake_req,
    output logic                   cascade_en,
    output logic                   cascade_tick
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    logic [7:0]       count_reg;
    logic             ovf_reg;
    logic             cas_reg;
    logic             ovf_ie_reg;
    logic             run_reg;
    logic [SEL_W-1:0] sel_reg;
    logic [IRQ_W-1:0] irq_stat_reg;
    logic [IRQ_W-1:0] irq_mask_reg;
    logic [7:0]       rd_data_reg;
    logic             irq_reg;
    logic             wake_reg;
    logic             casc_tick_reg;

    logic             tick;
    logic             step;
    logic             wrap;
    logic             wr_count;
    logic             wr_ctrl;
    logic             rd_ctrl;
    logic [7:0]       ctrl_view;
    logic [7:0]       count_next;
    logic             irq_next;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    assign wr_count = wr_en && (addr == OFF_COUNT);
    assign wr_ctrl  = wr_en && (addr == OFF_CTRL);
    assign rd_ctrl  = rd_en && (addr == OFF_CTRL);

    // ----------------------------------------------------------------
    // prescaler
    // ----------------------------------------------------------------
    tbc_prescaler u_prescaler (
        .clk    (clk),
        .rst_n  (rst_n),
        .clk_en (clk_en),
        .run    (run_reg),
        .hold   (halt_mode),
        .sel    (sel_reg),
        .tick   (tick)
    );

    // ----------------------------------------------------------------
    // counter
    // ----------------------------------------------------------------
    // a software write to the count in the same cycle as a tick wins; that tick is lost
    assign step = tick && !wr_count;
    assign wrap = step && (count_reg == COUNT_MAX);

    always_comb begin
        if (wr_count) begin
            count_next = wr_data;
        end else if (step) begin
            count_next = count_reg + 8'h01;
        end else begin
            count_next = count_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= COUNT_RESET;
        end else if (clk_en) begin
            count_reg <= count_next;
        end
    end

    // ----------------------------------------------------------------
    // control fields
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cas_reg    <= CTRL_RESET[BIT_CASCADE];
            ovf_ie_reg <= CTRL_RESET[BIT_OVF_IE];
            run_reg    <= CTRL_RESET[BIT_RUN];
            sel_reg    <= CTRL_RESET[SEL_MSB:0];
        end else if (clk_en && wr_ctrl) begin
            cas_reg    <= wr_data[BIT_CASCADE];
            ovf_ie_reg <= wr_data[BIT_OVF_IE];
            run_reg    <= wr_data[BIT_RUN];
            sel_reg    <= wr_data[SEL_MSB:0];
        end
    end

    // ----------------------------------------------------------------
    // overflow flag
    // ----------------------------------------------------------------
    // writes never touch it; a wrap in the read cycle survives the read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ovf_reg <= CTRL_RESET[BIT_OVF];
        end else if (clk_en) begin
            if (wrap) begin
                ovf_reg <= 1'b1;
            end else if (rd_ctrl) begin
                ovf_reg <= 1'b0;
            end
        end
    end

    always_comb begin
        ctrl_view               = CTRL_RESET & CTRL_WR_MASK;
        ctrl_view[BIT_RESERVED] = 1'b0;
        ctrl_view[BIT_CASCADE]  = cas_reg;
        ctrl_view[BIT_OVF]      = ovf_reg;
        ctrl_view[BIT_OVF_IE]   = ovf_ie_reg;
        ctrl_view[BIT_RUN]      = run_reg;
        ctrl_view[SEL_MSB:0]    = sel_reg;
    end

    // ----------------------------------------------------------------
    // interrupt status and mask
    // ----------------------------------------------------------------
    // status bits are write-one-to-clear; a new event wins over the clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_reg <= IRQ_RESET;
        end else if (clk_en) begin
            for (int i = 0; i < IRQ_W; i++) begin
                if ((i == IRQ_OVERFLOW) && wrap) begin
                    irq_stat_reg[i] <= 1'b1;
                end else if ((i == IRQ_CASCADE) && wrap && cas_reg) begin
                    irq_stat_reg[i] <= 1'b1;
                end else if (wr_en && (addr == OFF_IRQ_STATUS) && wr_data[i]) begin
                    irq_stat_reg[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask_reg <= IRQ_RESET;
        end else if (clk_en && wr_en && (addr == OFF_IRQ_MASK)) begin
            irq_mask_reg <= wr_data[IRQ_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // interrupt and wake outputs
    // ----------------------------------------------------------------
    assign irq_next = (ovf_reg && ovf_ie_reg) || (|(irq_stat_reg & irq_mask_reg));

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_reg <= 1'b0;
        end else if (clk_en) begin
            irq_reg <= irq_next;
        end
    end

    // halt only holds the prescaler while clk keeps running; wake is gated off whenever halt_mode is set
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wake_reg <= 1'b0;
        end else if (clk_en) begin
            wake_reg <= irq_next && wait_mode && !halt_mode;
        end
    end

    // ----------------------------------------------------------------
    // cascade toward the auto-reload timer
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            casc_tick_reg <= 1'b0;
        end else if (clk_en) begin
            casc_tick_reg <= wrap && cas_reg;
        end
    end

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_reg <= 8'h00;
        end else if (clk_en) begin
            if (!rd_en) begin
                rd_data_reg <= 8'h00;
            end else if (addr == OFF_COUNT) begin
                rd_data_reg <= count_reg;
            end else if (addr == OFF_CTRL) begin
                rd_data_reg <= ctrl_view;
            end else if (addr == OFF_IRQ_STATUS) begin
                rd_data_reg <= {6'h00, irq_stat_reg};
            end else begin
                rd_data_reg <= {6'h00, irq_mask_reg};
            end
        end
    end

    assign rd_data      = rd_data_reg;
    assign irq          = irq_reg;
    assign wake_req     = wake_reg;
    assign cascade_en   = cas_reg;
    assign cascade_tick = casc_tick_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_tick_idle;
        clk_en && run_reg && !halt_mode && !wr_en && (sel_reg == 3'd1);
    endsequence

    sequence s_quiet_period;
        s_tick_idle [*3];
    endsequence

    a_count_step: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && tick && !wr_count) |=> (count_reg == 8'($past(count_reg) + 8'h01)))
        else $error("count did not step on tick");

    a_count_write: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && wr_count) |=> (count_reg == $past(wr_data)))
        else $error("count write not taken");

    a_reserved_zero: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && rd_ctrl) |=> (rd_data[BIT_RESERVED] == 1'b0))
        else $error("reserved bit read as one");

    a_cascade_pulse: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && wrap) |=> (cascade_tick == $past(cas_reg)))
        else $error("cascade pulse wrong");

    a_ovf_on_wrap: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && tick && !wr_count && (count_reg == 8'hFF))
            |=> (ovf_reg && (count_reg == 8'h00)))
        else $error("wrap did not set overflow");

    a_ovf_set_cause: assert property (
        @(posedge clk) disable iff (!rst_n)
        $rose(ovf_reg) |-> $past(wrap))
        else $error("overflow set without wrap");

    a_read_clears: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && rd_ctrl && !wrap) |=> (!ovf_reg && rd_data[BIT_OVF] == $past(ovf_reg)))
        else $error("control read did not clear overflow");

    a_ovf_write_ign: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && wr_ctrl && !wrap) |=> (ovf_reg == $past(ovf_reg)))
        else $error("write changed overflow");

    a_irq_request: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && ovf_reg && ovf_ie_reg) |=> irq)
        else $error("overflow request missing");

    a_frozen_hold: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && !run_reg && !wr_count) |=> $stable(count_reg) ##0 !tick)
        else $error("count moved while frozen");

    a_divide_four: assert property (
        @(posedge clk) disable iff (!rst_n)
        (s_tick_idle and tick) ##1 s_quiet_period |=> (tick || halt_mode))
        else $error("divide by four period wrong");

    a_wake_gate: assert property (
        @(posedge clk) disable iff (!rst_n)
        wake_req |-> ($past(wait_mode) && !$past(halt_mode)))
        else $error("wake outside wait");

    a_halt_stop: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && halt_mode && !wr_count) |=> $stable(count_reg))
        else $error("count moved in halt");

    a_no_stray_step: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && !tick && !wr_count) |=> $stable(count_reg))
        else $error("count moved without tick");

    a_count_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && rd_en && (addr == OFF_COUNT)) |=> (rd_data == $past(count_reg)))
        else $error("count read returned wrong value");

    a_casc_off: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && !cas_reg) |=> !cascade_tick)
        else $error("cascade pulse while not cascaded");

    a_ovf_sticky: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && ovf_reg && !rd_ctrl) |=> ovf_reg)
        else $error("overflow lost without a read");

    a_irq_quiet: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && !(ovf_reg && ovf_ie_reg) && !(|(irq_stat_reg & irq_mask_reg))) |=> !irq)
        else $error("request without a source");

    a_stat_sticky: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && irq_stat_reg[IRQ_OVERFLOW] && !(wr_en && (addr == OFF_IRQ_STATUS)))
            |=> irq_stat_reg[IRQ_OVERFLOW])
        else $error("status bit lost without a clear");

    a_ctrl_fields: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && wr_ctrl) |=> ((run_reg == $past(wr_data[BIT_RUN])) && (sel_reg == $past(wr_data[SEL_MSB:0]))))
        else $error("control write not taken");

    a_wake_in_wait: assert property (
        @(posedge clk) disable iff (!rst_n)
        (clk_en && irq_next && wait_mode && !halt_mode) |=> wake_req)
        else $error("wake missing in wait");

endmodule // tbc_top
`default_nettype wire

// ---- test/tbc_top_tb.sv ----
// self-checking bench for the timebase counter: register port, prescaler, overflow, irq, wake
// assumes the design files from rtl/ are compiled first; single clock, no partner model
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tbc_top_tb;
    import tbc_pkg::*;

    logic              clk;
    logic              rst_n;
    logic              clk_en;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wr_data;
    logic              wr_en;
    logic              rd_en;
    logic [7:0]        rd_data;
    logic              halt_mode;
    logic              wait_mode;
    logic              irq;
    logic              wake_req;
    logic              cascade_en;
    logic              cascade_tick;
    logic [7:0]        v;
    logic [7:0]        v2;
    int                n_errors;
    int                n_tests;

    tbc_top dut_u (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .halt_mode(halt_mode),
        .wait_mode(wait_mode), .irq(irq), .wake_req(wake_req), .cascade_en(cascade_en),
        .cascade_tick(cascade_tick));

    // ----------------------------------------------------------------
    // clock, bus tasks
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'b1;
        @(posedge clk);
        wr_en   <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 d = rd_data;
    endtask

    task automatic wait_irq();
        for (int i = 0; i < 2000 && irq !== 1'b1; i++) @(posedge clk);
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset_regs();
        rd(OFF_COUNT, v);      `CHK(v, COUNT_RESET)
        rd(OFF_CTRL, v);       `CHK(v, CTRL_RESET)
        rd(OFF_IRQ_STATUS, v); `CHK(v, 8'h00)
        rd(OFF_IRQ_MASK, v);   `CHK(v, 8'h00)
        `CHK(irq, 1'b0)
    endtask

    task automatic t_access();
        wr(OFF_COUNT, 8'hA5);
        rd(OFF_COUNT, v);      `CHK(v, 8'hA5)
        wr(OFF_CTRL, 8'hF7);   // stopped: reserved and flag bits must not stick
        rd(OFF_CTRL, v);       `CHK(v, 8'h57)
        `CHK(v[BIT_OVF], 1'b0)
        `CHK(cascade_en, 1'b1)
        // a frozen clock enable must swallow the strobe
        @(posedge clk);
        clk_en <= 1'b0;
        wr(OFF_COUNT, 8'h3C);
        @(posedge clk);
        clk_en <= 1'b1;
        rd(OFF_COUNT, v);      `CHK(v, 8'hA5)
        wr(OFF_CTRL, 8'h00);
        #1 `CHK(cascade_en, 1'b0)
    endtask

    // four and a half prescaled periods must give exactly four counts, for each select code
    task automatic t_prescale();
        int d;
        for (int s = 0; s < 8; s++) begin
            d = 2 << s;
            wr(OFF_COUNT, 8'h00);
            wr(OFF_CTRL, {5'b0_0001, 3'(s)});
            // the stopping write lands two edges after this wait, so leave room for it
            repeat (d * 4 + d / 2 - 2) @(posedge clk);
            wr(OFF_CTRL, 8'h00);
            rd(OFF_COUNT, v);  `CHK(v, 8'h04)
            repeat (20) @(posedge clk);
            rd(OFF_COUNT, v2); `CHK(v2, v)
        end
    endtask

    task automatic t_overflow();
        wr(OFF_COUNT, 8'hFE);
        wr(OFF_CTRL, 8'h18);
        wait_irq();
        `CHK(irq, 1'b1)
        wr(OFF_CTRL, 8'h10);
        rd(OFF_COUNT, v);      `CHK(v <= 8'h03, 1'b1)
        wr(OFF_CTRL, 8'h30);   // writing the flag position must not clear it
        rd(OFF_CTRL, v);       `CHK(v, 8'h30)
        rd(OFF_CTRL, v);       `CHK(v, 8'h10)
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0)
        wr(OFF_IRQ_STATUS, 8'h03);
        wr(OFF_CTRL, 8'h00);
    endtask

    task automatic t_cascade_irq();
        wr(OFF_COUNT, 8'hFE);
        wr(OFF_CTRL, 8'h48);
        for (int i = 0; i < 100 && cascade_tick !== 1'b1; i++) @(posedge clk);
        `CHK(cascade_tick, 1'b1)
        @(posedge clk);
        #1 `CHK(cascade_tick, 1'b0)
        wr(OFF_CTRL, 8'h40);
        `CHK(irq, 1'b0)
        rd(OFF_IRQ_STATUS, v); `CHK(v, 8'h03)
        wr(OFF_IRQ_MASK, 8'h01);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b1)
        wr(OFF_IRQ_STATUS, 8'h01);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0)
        rd(OFF_IRQ_STATUS, v); `CHK(v, 8'h02)
        wr(OFF_IRQ_STATUS, 8'h02);
        wr(OFF_IRQ_MASK, 8'h00);
        rd(OFF_CTRL, v);       `CHK(v, 8'h60)
        wr(OFF_CTRL, 8'h00);
    endtask

    task automatic t_low_power();
        @(posedge clk);
        wait_mode <= 1'b1;
        wr(OFF_COUNT, 8'hFE);
        wr(OFF_CTRL, 8'h18);
        wait_irq();
        @(posedge clk);
        #1 `CHK(wake_req, 1'b1)
        @(posedge clk);
        halt_mode <= 1'b1;
        repeat (3) @(posedge clk);
        #1 `CHK(wake_req, 1'b0)
        rd(OFF_COUNT, v);
        repeat (30) @(posedge clk);
        rd(OFF_COUNT, v2);     `CHK(v2, v)
        @(posedge clk);
        halt_mode <= 1'b0;
        repeat (40) @(posedge clk);
        rd(OFF_COUNT, v2);     `CHK(v2 != v, 1'b1)
        @(posedge clk);
        wait_mode <= 1'b0;
        wr(OFF_CTRL, 8'h00);
        rd(OFF_CTRL, v);
        wr(OFF_IRQ_STATUS, 8'h03);
    endtask

    // ----------------------------------------------------------------
    // verdict, watchdog, main sequence
    // ----------------------------------------------------------------
    task automatic results();
        $display("errors %0d of %0d checks", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        // the whole run needs about 2700 cycles, so 20k cycles is a generous limit
        #200_000;
        n_errors++;
        results();
    end

    initial begin
        n_errors  = 0;
        n_tests   = 0;
        rst_n     = 1'b0;
        clk_en    = 1'b1;
        addr      = '0;
        wr_data   = 8'h00;
        wr_en     = 1'b0;
        rd_en     = 1'b0;
        halt_mode = 1'b0;
        wait_mode = 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_reset_regs();
        t_access();
        t_prescale();
        t_overflow();
        t_cascade_irq();
        t_low_power();
        results();
    end
endmodule // tbc_top_tb
`default_nettype wire
